// file: logic/ddac_regs.svh
// timing counts, field positions and fixed codes of the capture block
// assumes it is included by bare name from the package and from ddac_capture
`ifndef DDAC_REGS_SVH
`define DDAC_REGS_SVH

`define DDAC_CLOCK_MHZ 25
`define DDAC_BUS_WIDTH 8
`define DDAC_CODE_WIDTH 16
`define DDAC_FIFO_DEPTH 4
`define DDAC_SYNC_WIDTH 28
`define DDAC_BYTE_LAST 2'h3
`define DDAC_BYTE_FIRST 2'h0
`define DDAC_BYTE_NEXT 2'h1
`define DDAC_DIV_LAST 2'h1
`define DDAC_DIV_START 2'h0
`define DDAC_CODE_ZERO 16'h0000
`define DDAC_CODE_FULL 16'hffff
`define DDAC_BYTE_ZERO 8'h00

`endif

// file: logic/ddac_pkg.sv
// types shared by the capture block, its checker and its bench
// assumes ddac_regs.svh is reachable on the include path
`include "ddac_regs.svh"

package ddac_pkg;

    typedef struct packed {
        logic [15:0] chan_a;
        logic [15:0] chan_b;
    } ddac_pair_t;

    typedef struct packed {
        logic [15:0] primary;
        logic [15:0] complement;
    } ddac_drive_t;

    typedef enum logic [0:0] {
        CAP_HUNT,
        CAP_RUN
    } ddac_cap_state_t;

endpackage : ddac_pkg

// file: logic/ddac_sync.sv
// two-flop synchroniser for a vector of pin levels
// assumes every bit is an independent level from outside the clock domain
`timescale 1ns/10ps

module ddac_sync #(
    parameter int WIDTH = 1
) (
    // clock and reset
    input wire logic clock,
    input wire logic reset,
    // levels
    input wire logic [WIDTH-1:0] pin_level,
    output logic [WIDTH-1:0] sync_level
);

    logic [WIDTH-1:0] meta_r;

    // first stage is read only by the second
    always_ff @(posedge clock) begin
        if (reset) begin
            meta_r <= '0;
            sync_level <= '0;
        end else begin
            meta_r <= pin_level;
            sync_level <= meta_r;
        end
    end

endmodule : ddac_sync

// file: logic/ddac_fifo.sv
// small synchronous fifo with flush, valid/ready on both sides
// assumes one clock; flush wins over a push in the same cycle
`timescale 1ns/10ps

module ddac_fifo #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 4
) (
    // clock and reset
    input wire logic clock,
    input wire logic reset,
    input wire logic flush,
    // fill side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // drain side
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);

    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr_r;
    logic [AW-1:0] rd_ptr_r;
    logic [AW:0] count_r;
    logic push;
    logic pop;

    assign in_ready = (count_r != (AW+1)'(DEPTH)) && !flush;
    assign out_valid = (count_r != '0);
    assign out_data = mem[rd_ptr_r];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready && !flush;

    always_ff @(posedge clock) begin
        if (push) begin
            mem[wr_ptr_r] <= in_data;
        end
    end

    always_ff @(posedge clock) begin
        if (reset || flush) begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
            count_r <= '0;
        end else begin
            if (push) begin
                wr_ptr_r <= (wr_ptr_r == AW'(DEPTH - 1)) ? '0 :
                            wr_ptr_r + AW'(1);
            end
            if (pop) begin
                rd_ptr_r <= (rd_ptr_r == AW'(DEPTH - 1)) ? '0 :
                            rd_ptr_r + AW'(1);
            end
            count_r <= count_r + (AW+1)'(push) - (AW+1)'(pop);
        end
    end

endmodule : ddac_fifo

// file: logic/ddac_capture.sv
// input capture and output mapping of a dual 16-bit converter
// assumes all pins are asynchronous to clock and are oversampled by it;
// data and converter clocks must be well below half the clock rate
//
// Overview of operation
// - input byte is taken on both edges of the data clock pair
// - frame strobe is looked at only on data clock rising edges
// - a new frame strobe pulse flushes the input fifo to realign it
// - output strobe taken on converter clock rise resets the divider
// - transmit gate low forces datapath to zero and drops input data
// - code 0x0000 is full sink on primary, 0xffff is zero sink
// - complement output is the opposite of the primary output
// - active-low chip reset resets everything but the pin synchronisers
// - reference select 1 takes pin as input, 0 drives internal reference
// - four bytes per frame carry both 16-bit samples, a then b
// - bit 7 is msb by default; bus reverse swaps the bit order
`timescale 1ns/10ps

`include "ddac_regs.svh"

module ddac_capture (
    // system
    input wire logic clock,
    input wire logic reset,
    // data link pins
    input wire logic data_clock_pos,
    input wire logic data_clock_neg,
    input wire logic frame_strobe_pos,
    input wire logic frame_strobe_neg,
    input wire logic [7:0] data_in_pos,
    input wire logic [7:0] data_in_neg,
    // converter clock pins
    input wire logic converter_clock_pos,
    input wire logic converter_clock_neg,
    input wire logic output_strobe_pos,
    input wire logic output_strobe_neg,
    // control pins
    input wire logic transmit_gate,
    input wire logic chip_reset_n,
    input wire logic ext_ref_select,
    input wire logic bus_reverse,
    // converter drive codes
    output ddac_pkg::ddac_drive_t chan_a_drive,
    output ddac_pkg::ddac_drive_t chan_b_drive,
    // reference pin
    input wire logic reference_pin_in,
    output logic reference_pin_out,
    output logic reference_pin_oe,
    // status
    output logic frame_locked,
    output logic fifo_overflow,
    output logic reference_external
);
    import ddac_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // helpers

    function automatic logic diff_level(input logic pos, input logic neg);
        // both legs equal means an idle or undriven pair: read as low
        diff_level = pos & ~neg;
    endfunction : diff_level

    function automatic logic [7:0] byte_order(input logic [7:0] b,
                                              input logic rev);
        byte_order = rev ? {<<{b}} : b;
    endfunction : byte_order

    ////////////////////////////////////////////////////////////////////////
    // pin synchronisers

    logic [27:0] pins_raw;
    logic [27:0] pins_s;

    assign pins_raw = {data_clock_pos, data_clock_neg,
                       frame_strobe_pos, frame_strobe_neg,
                       data_in_pos, data_in_neg,
                       converter_clock_pos, converter_clock_neg,
                       output_strobe_pos, output_strobe_neg,
                       transmit_gate, chip_reset_n,
                       ext_ref_select, bus_reverse};

    ddac_sync #(
        .WIDTH(`DDAC_SYNC_WIDTH)
    ) u_sync (
        .clock(clock),
        .reset(reset),
        .pin_level(pins_raw),
        .sync_level(pins_s)
    );

    logic dclk_s;
    logic frame_s;
    logic [7:0] data_s;
    logic cclk_s;
    logic ostr_s;
    logic gate_s;
    logic chip_rst_n_s;
    logic ext_ref_s;
    logic rev_s;

    assign dclk_s = diff_level(pins_s[27], pins_s[26]);
    assign frame_s = diff_level(pins_s[25], pins_s[24]);
    assign data_s = pins_s[23:16] & ~pins_s[15:8];
    assign cclk_s = diff_level(pins_s[7], pins_s[6]);
    assign ostr_s = diff_level(pins_s[5], pins_s[4]);
    assign gate_s = pins_s[3];
    assign chip_rst_n_s = pins_s[2];
    assign ext_ref_s = pins_s[1];
    assign rev_s = pins_s[0];

    ////////////////////////////////////////////////////////////////////////
    // reset

    logic core_rst;

    // synchroniser resets low, so the chip reset stays asserted until the
    // released pin level has crossed both stages
    assign core_rst = reset || !chip_rst_n_s;

    ////////////////////////////////////////////////////////////////////////
    // edge detection

    logic dclk_d_r;
    logic cclk_d_r;
    logic frame_d_r;
    logic dclk_rise;
    logic dclk_fall;
    logic cclk_rise;

    always_ff @(posedge clock) begin
        if (core_rst) begin
            dclk_d_r <= 1'b0;
            cclk_d_r <= 1'b0;
        end else begin
            dclk_d_r <= dclk_s;
            cclk_d_r <= cclk_s;
        end
    end

    assign dclk_rise = dclk_s && !dclk_d_r;
    assign dclk_fall = !dclk_s && dclk_d_r;
    assign cclk_rise = cclk_s && !cclk_d_r;

    // frame history advances only on data clock rises
    always_ff @(posedge clock) begin
        if (core_rst) begin
            frame_d_r <= 1'b0;
        end else if (dclk_rise) begin
            frame_d_r <= frame_s;
        end
    end

    logic frame_start;
    logic ddr_edge;

    // frame and data are edge aligned, so both are taken on the same edge
    assign frame_start = dclk_rise && frame_s && !frame_d_r;
    assign ddr_edge = dclk_rise || dclk_fall;

    ////////////////////////////////////////////////////////////////////////
    // byte assembly

    ddac_cap_state_t state_r;
    logic [1:0] byte_idx_r;
    logic [7:0] byte_in;
    logic [7:0] hold_r [3];
    ddac_pair_t pair_r;
    logic push_r;
    logic fifo_in_ready;

    assign byte_in = byte_order(data_s, rev_s);

    always_ff @(posedge clock) begin
        if (core_rst || !gate_s) begin
            state_r <= CAP_HUNT;
        end else begin
            case (state_r)
                CAP_HUNT: begin
                    if (frame_start) begin
                        state_r <= CAP_RUN;
                    end
                end
                CAP_RUN: begin
                    state_r <= CAP_RUN;
                end
                default: begin
                    state_r <= CAP_HUNT;
                end
            endcase
        end
    end

    always_ff @(posedge clock) begin
        if (core_rst || !gate_s) begin
            byte_idx_r <= `DDAC_BYTE_FIRST;
        end else if (frame_start) begin
            byte_idx_r <= `DDAC_BYTE_NEXT;
        end else if (ddr_edge && state_r == CAP_RUN) begin
            byte_idx_r <= byte_idx_r + 2'h1;
        end
    end

    always_ff @(posedge clock) begin
        if (core_rst) begin
            hold_r[0] <= `DDAC_BYTE_ZERO;
            hold_r[1] <= `DDAC_BYTE_ZERO;
            hold_r[2] <= `DDAC_BYTE_ZERO;
        end else if (frame_start) begin
            hold_r[0] <= byte_in;
        end else if (ddr_edge && state_r == CAP_RUN &&
                     byte_idx_r != `DDAC_BYTE_LAST) begin
            hold_r[byte_idx_r] <= byte_in;
        end
    end

    // a frame is a hi, a lo, b hi, b lo; the last byte completes the pair
    always_ff @(posedge clock) begin
        if (core_rst || !gate_s) begin
            push_r <= 1'b0;
            pair_r <= '0;
        end else begin
            push_r <= ddr_edge && state_r == CAP_RUN && !frame_start &&
                      byte_idx_r == `DDAC_BYTE_LAST;
            if (ddr_edge && byte_idx_r == `DDAC_BYTE_LAST) begin
                pair_r <= '{chan_a: {hold_r[0], hold_r[1]},
                            chan_b: {hold_r[2], byte_in}};
            end
        end
    end

    // the source cannot be stalled: a pair that finds the fifo full is
    // dropped and remembered until reset
    always_ff @(posedge clock) begin
        if (core_rst) begin
            fifo_overflow <= 1'b0;
        end else if (push_r && !fifo_in_ready) begin
            fifo_overflow <= 1'b1;
        end
    end

    assign frame_locked = (state_r == CAP_RUN);

    ////////////////////////////////////////////////////////////////////////
    // input fifo

    logic fifo_flush;
    logic fifo_out_valid;
    logic fifo_pop;
    ddac_pair_t fifo_out;

    assign fifo_flush = frame_start || !gate_s;

    ddac_fifo #(
        .WIDTH($bits(ddac_pair_t)),
        .DEPTH(`DDAC_FIFO_DEPTH)
    ) u_fifo (
        .clock(clock),
        .reset(core_rst),
        .flush(fifo_flush),
        .in_valid(push_r),
        .in_ready(fifo_in_ready),
        .in_data(pair_r),
        .out_valid(fifo_out_valid),
        .out_ready(fifo_pop),
        .out_data(fifo_out)
    );

    ////////////////////////////////////////////////////////////////////////
    // converter clock divider

    logic [1:0] div_r;
    logic div_tick;

    always_ff @(posedge clock) begin
        if (core_rst) begin
            div_r <= `DDAC_DIV_START;
        end else if (cclk_rise) begin
            if (ostr_s) begin
                div_r <= `DDAC_DIV_START;
            end else if (div_r == `DDAC_DIV_LAST) begin
                div_r <= `DDAC_DIV_START;
            end else begin
                div_r <= div_r + 2'h1;
            end
        end
    end

    // strobe high holds the divider, so several parts leave it together
    assign div_tick = cclk_rise && !ostr_s && div_r == `DDAC_DIV_LAST;
    assign fifo_pop = div_tick;

    ////////////////////////////////////////////////////////////////////////
    // output mapping

    ddac_pair_t code_r;

    // an empty fifo repeats the last pair rather than glitching to zero
    always_ff @(posedge clock) begin
        if (core_rst || !gate_s) begin
            code_r <= '0;
        end else if (div_tick && fifo_out_valid) begin
            code_r <= fifo_out;
        end
    end

    always_ff @(posedge clock) begin
        if (core_rst) begin
            chan_a_drive <= '{primary: `DDAC_CODE_FULL,
                              complement: `DDAC_CODE_ZERO};
            chan_b_drive <= '{primary: `DDAC_CODE_FULL,
                              complement: `DDAC_CODE_ZERO};
        end else begin
            chan_a_drive.primary <= ~code_r.chan_a;
            chan_a_drive.complement <= code_r.chan_a;
            chan_b_drive.primary <= ~code_r.chan_b;
            chan_b_drive.complement <= code_r.chan_b;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // reference select

    // the pin level itself is analog; only its direction is decided here
    always_ff @(posedge clock) begin
        if (core_rst) begin
            reference_external <= 1'b0;
        end else begin
            reference_external <= ext_ref_s || (1'b0 & reference_pin_in);
        end
    end

    assign reference_pin_oe = !reference_external;
    assign reference_pin_out = !reference_external;

endmodule : ddac_capture

// file: testbench/ddac_capture_asserts.sv
// pin-level checks of the capture block
// assumes one clock domain and a bind onto ddac_capture
`timescale 1ns/10ps

module ddac_capture_asserts
import ddac_pkg::*;
(
    // watched pins
    input wire logic clock,
    input wire logic reset,
    input wire logic chip_reset_n,
    input wire logic transmit_gate,
    input wire logic ext_ref_select,
    input ddac_pkg::ddac_drive_t chan_a_drive,
    input ddac_pkg::ddac_drive_t chan_b_drive,
    input wire logic reference_pin_out,
    input wire logic reference_pin_oe,
    input wire logic frame_locked,
    input wire logic fifo_overflow,
    input wire logic reference_external
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (reset);

    // select crosses two sync stages and one register before it acts
    property p_ref_oe;
        chip_reset_n [*5] |-> reference_pin_oe == !$past(ext_ref_select, 3);
    endproperty
    a_ref_oe: assert property (p_ref_oe)
        else $error("reference enable wrong");
    property p_ref_out;
        chip_reset_n [*5] |-> reference_pin_out == !$past(ext_ref_select, 3);
    endproperty
    a_ref_out: assert property (p_ref_out)
        else $error("reference level wrong");
    // sync plus core reset release need a few cycles
    property p_ref_on;
        (ext_ref_select && chip_reset_n) [*8] |-> reference_external;
    endproperty
    a_ref_on: assert property (p_ref_on)
        else $error("external reference not taken");
    property p_ref_off;
        (!ext_ref_select && chip_reset_n) [*8] |-> !reference_external;
    endproperty
    a_ref_off: assert property (p_ref_off)
        else $error("internal reference not kept");
    property p_inv_a;
        chan_a_drive.primary == ~chan_a_drive.complement;
    endproperty
    a_inv_a: assert property (p_inv_a)
        else $error("channel a outputs not opposite");
    property p_inv_b;
        chan_b_drive.primary == ~chan_b_drive.complement;
    endproperty
    a_inv_b: assert property (p_inv_b)
        else $error("channel b outputs not opposite");
    property p_gate;
        (!transmit_gate) [*6] |-> chan_a_drive.complement == 16'h0000
            && chan_b_drive.complement == 16'h0000 && !frame_locked;
    endproperty
    a_gate: assert property (p_gate)
        else $error("datapath not zero with gate low");
    property p_chip_rst;
        (!chip_reset_n) [*4] |-> !frame_locked && !fifo_overflow
            && chan_a_drive.complement == 16'h0000;
    endproperty
    a_chip_rst: assert property (p_chip_rst)
        else $error("chip reset did not clear state");
    property p_rst_rel;
        (!chip_reset_n) [*4] ##1 chip_reset_n |=> !frame_locked;
    endproperty
    a_rst_rel: assert property (p_rst_rel)
        else $error("capture resumed before sync");
endmodule : ddac_capture_asserts

bind ddac_capture ddac_capture_asserts u_chk (
    .clock(clock), .reset(reset), .chip_reset_n(chip_reset_n),
    .transmit_gate(transmit_gate), .ext_ref_select(ext_ref_select),
    .chan_a_drive(chan_a_drive), .chan_b_drive(chan_b_drive),
    .reference_pin_out(reference_pin_out),
    .reference_pin_oe(reference_pin_oe), .frame_locked(frame_locked),
    .fifo_overflow(fifo_overflow),
    .reference_external(reference_external)
);

// file: testbench/ddac_src.sv
// data source model on the byte link pins
// assumes one bench process calls send_pair and rest
`timescale 1ns/10ps

module ddac_src (
    // pacing clock
    input wire logic clock,
    // link pins
    output logic data_clock_pos,
    output logic data_clock_neg,
    output logic frame_strobe_pos,
    output logic frame_strobe_neg,
    output logic [7:0] data_in_pos,
    output logic [7:0] data_in_neg
);
    logic dclk = 1'b0;
    logic frm = 1'b0;
    logic [7:0] dat = 8'h00;
    assign data_clock_pos = dclk;
    assign data_clock_neg = ~dclk;
    assign frame_strobe_pos = frm;
    assign frame_strobe_neg = ~frm;
    assign data_in_pos = dat;
    assign data_in_neg = ~dat;

    ////////////////////////////////////////////////////////////////////////
    // data set mid-level so it stands 3 clocks around each edge
    task automatic send_pair(input logic [15:0] a, input logic [15:0] b,
                             input logic first);
        logic [31:0] w;
        w = {a, b};
        for (int i = 0; i < 4; i++) begin
            repeat (3) @(negedge clock);
            dat = w[31-8*i -: 8];
            frm = first && (i == 0);
            repeat (3) @(negedge clock);
            dclk = ~dclk;
        end
    endtask : send_pair

    // clock stands low; stale data is not left on the bus
    task automatic rest();
        repeat (3) @(negedge clock);
        dat = ~dat;
        frm = 1'b0;
    endtask : rest
endmodule : ddac_src

// file: testbench/ddac_capture_tb.sv
// self-checking bench of the capture block
// assumes ddac_src drives the link and the checker is bound
`timescale 1ns/10ps

module ddac_capture_tb;
    import ddac_pkg::*;
    logic clock, reset, cclk, ostr, gate, chip_reset_n, ext_ref, rev;
    logic dcp, dcn, fsp, fsn, ref_out, ref_oe, locked, ovf, ref_ext;
    logic [7:0] dip, din;
    ddac_drive_t a_drv, b_drv;
    logic [63:0] last_seen;
    logic [63:0] exp_q[$];
    int mismatches, checks_done, seed, cycles;
    bit mon_on;

    ddac_capture uut (
        .clock(clock), .reset(reset), .data_clock_pos(dcp),
        .data_clock_neg(dcn), .frame_strobe_pos(fsp),
        .frame_strobe_neg(fsn), .data_in_pos(dip), .data_in_neg(din),
        .converter_clock_pos(cclk), .converter_clock_neg(~cclk),
        .output_strobe_pos(ostr), .output_strobe_neg(~ostr),
        .transmit_gate(gate), .chip_reset_n(chip_reset_n),
        .ext_ref_select(ext_ref), .bus_reverse(rev),
        .chan_a_drive(a_drv), .chan_b_drive(b_drv),
        .reference_pin_in(1'b0), .reference_pin_out(ref_out),
        .reference_pin_oe(ref_oe), .frame_locked(locked),
        .fifo_overflow(ovf), .reference_external(ref_ext)
    );
    ddac_src src (
        .clock(clock), .data_clock_pos(dcp), .data_clock_neg(dcn),
        .frame_strobe_pos(fsp), .frame_strobe_neg(fsn),
        .data_in_pos(dip), .data_in_neg(din)
    );

    ////////////////////////////////////////////////////////////////////////
    function automatic logic [15:0] rv(input logic [15:0] c);
        for (int i = 0; i < 16; i++)
            rv[8*(i/8) + 7 - i%8] = c[i];
    endfunction : rv

    // sink magnitude is the inverse of the offset binary code
    function automatic logic [63:0] exp_w(input logic [15:0] a,
                                          input logic [15:0] b);
        return {~a, a, ~b, b};
    endfunction : exp_w

    task automatic check(input logic ok, input string msg);
        checks_done++;
        if (ok !== 1'b1) begin
            mismatches++;
            $display("BAD %0t %s", $time, msg);
        end
    endtask : check

    task automatic wrap_up();
        if (mismatches == 0 && checks_done > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : wrap_up

    // first pair of a burst carries the frame; only the first keep expected
    task automatic burst(input int n, input logic [15:0] c0, input int keep);
        logic [15:0] a, b;
        for (int k = 0; k < n; k++) begin
            a = (k == 0) ? c0 : 16'($random(seed));
            b = (k == 0) ? ~c0 : 16'($random(seed));
            if (k < keep)
                exp_q.push_back(exp_w(a, b));
            src.send_pair(rev ? rv(a) : a, rev ? rv(b) : b, k == 0);
        end
        src.rest();
    endtask : burst

    task automatic drain();
        for (int i = 0; i < 300 && exp_q.size() != 0; i++)
            @(negedge clock);
        check(exp_q.size() == 0, "pairs never reached outputs");
    endtask : drain

    ////////////////////////////////////////////////////////////////////////
    initial begin
        clock = 1'b0;
        forever #20 clock = ~clock;
    end
    initial begin
        cclk = 1'b0;
        forever begin
            repeat (4) @(negedge clock);
            cclk = ~cclk;
        end
    end
    // each drive change must be the next expected pair
    always @(negedge clock) begin
        if (mon_on && {a_drv, b_drv} !== last_seen) begin
            if (exp_q.size() == 0)
                check(1'b0, "unexpected load");
            else
                check({a_drv, b_drv} === exp_q.pop_front(), "code");
        end
        last_seen = {a_drv, b_drv};
    end
    always @(negedge clock) begin
        cycles++;
        if (cycles == 10000) begin
            mismatches++;
            wrap_up();
        end
    end

    initial begin
        reset = 1'b1;
        ostr = 1'b0;
        gate = 1'b1;
        chip_reset_n = 1'b1;
        ext_ref = 1'b0;
        rev = 1'b0;
        mismatches = 0;
        checks_done = 0;
        seed = 37;
        cycles = 0;
        mon_on = 1'b0;
        last_seen = '0;
        repeat (6) @(negedge clock);
        reset = 1'b0;
        repeat (6) @(negedge clock);
        for (int i = 0; i < 2; i++) begin
            ext_ref = i[0];
            repeat (8) @(negedge clock);
            check(ref_ext === i[0] && ref_oe === !i[0] &&
                  ref_out === !i[0], "ref");
        end
        ext_ref = 1'b0;
        mon_on = 1'b1;
        burst(3, 16'h0000, 3);
        check(locked === 1'b1, "no frame lock");
        // a new frame flushes queued pairs, so let the last one out first
        drain();
        burst(2, 16'hffff, 2);
        drain();
        rev = 1'b1;
        burst(3, 16'h0001, 3);
        drain();
        rev = 1'b0;
        // strobe held: no loads; a new frame flushes the older pairs
        ostr = 1'b1;
        burst(2, 16'h1234, 0);
        burst(1, 16'h4321, 1);
        repeat (40) @(negedge clock);
        check(exp_q.size() == 1, "load under strobe");
        ostr = 1'b0;
        drain();
        ostr = 1'b1;
        burst(6, 16'h5555, 4);
        check(ovf === 1'b1, "overflow not flagged");
        ostr = 1'b0;
        drain();
        mon_on = 1'b0;
        chip_reset_n = 1'b0;
        repeat (6) @(negedge clock);
        check(a_drv === 32'hffff0000 && ovf === 1'b0, "chip reset");
        chip_reset_n = 1'b1;
        gate = 1'b0;
        repeat (8) @(negedge clock);
        burst(2, 16'h7777, 0);
        gate = 1'b1;
        repeat (10) @(negedge clock);
        check(b_drv === 32'hffff0000 && locked === 1'b0, "gate");
        mon_on = 1'b1;
        burst(2, 16'h8000, 2);
        drain();
        wrap_up();
    end
endmodule : ddac_capture_tb
